/* pci_internal_bus_translator.v */
`timescale 1ns/100ps
`default_nettype none
`include "bridge_defines.vh"
module pci_internal_bus_translator #(
  parameter IN_RD_DEPTH = `IN_RD_DEPTH,
  parameter IN_WR_DEPTH = `IN_WR_DEPTH,
  parameter OB_RD_DEPTH = `OB_RD_DEPTH,
  parameter OB_WR_DEPTH = `OB_WR_DEPTH
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        pcix_mode,
  input  wire [31:0] win0_base,
  input  wire [31:0] win0_upper,
  input  wire [31:0] win0_limit,
  input  wire [31:0] win0_xlate,
  input  wire [31:0] rom_base,
  input  wire [31:0] rom_limit,
  input  wire [31:0] rom_xlate,
  input  wire [31:0] ob_xlate,
  input  wire [31:0] ob_upper,
  input  wire        in_valid,
  input  wire [3:0]  in_cmd,
  input  wire        in_dac,
  input  wire [63:0] in_addr,
  input  wire [63:0] in_data,
  input  wire [2:0]  in_tag,
  output reg         in_claim,
  output reg         in_retry,
  output reg         ib_req,
  output reg         ib_write,
  output reg  [1:0]  ib_dest,
  output reg  [31:0] ib_addr,
  output reg  [63:0] ib_wdata,
  input  wire        ib_ack,
  input  wire [63:0] ib_rdata,
  output reg         cpl_valid,
  output reg  [2:0]  cpl_tag,
  output reg  [63:0] cpl_data,
  input  wire        ob_valid,
  input  wire        ob_write,
  input  wire        ob_burst,
  input  wire [31:0] ob_addr,
  input  wire [63:0] ob_data,
  input  wire [2:0]  ob_tag,
  output reg         ob_accept,
  output reg         ob_retry,
  output reg         ob_error,
  output reg         pci_req,
  output reg  [3:0]  pci_cmd,
  output reg         pci_dac,
  output reg  [63:0] pci_addr,
  output reg  [63:0] pci_wdata,
  input  wire        pci_done,
  input  wire [63:0] pci_rdata,
  output reg         ob_rsp_valid,
  output reg  [2:0]  ob_rsp_tag,
  output reg  [63:0] ob_rsp_data
);
  ////////////////////////////////////////////////////////////////
  // command and capability decode
  // inbound claim set
  // dac first cycle arrives folded into in_dac
  function claimable;
    input [3:0] c;
    input       dac;
    input       x;
    begin
      case (c)
        `CMD_MEM_RD, `CMD_MEM_WR, `CMD_CFG_RD, `CMD_CFG_WR,
        `CMD_RD_MULT, `CMD_RD_BLOCK, `CMD_WR_BLOCK:
          claimable = 1'b1;
        `CMD_ALIAS_RD, `CMD_ALIAS_WR:
          claimable = x | dac;
        default:
          claimable = 1'b0;
      endcase
    end
  endfunction
  function is_write;
    input [3:0] c;
    begin
      is_write = (c == `CMD_MEM_WR) || (c == `CMD_ALIAS_WR) ||
                 (c == `CMD_CFG_WR) || (c == `CMD_WR_BLOCK);
    end
  endfunction
  function [32:0] cap_word;
    input [7:0] o;
    begin
      case (o)
        `CAP_PTR_OFF:  cap_word = {1'b1, 24'h000000, `CAP_PM_OFF};
        `CAP_PM_OFF:   cap_word = {1'b1, 16'h0000, `CAP_MSI_OFF, `CAP_ID_PM};
        `CAP_MSI_OFF:  cap_word = {1'b1, 16'h0000, `CAP_PCIX_OFF, `CAP_ID_MSI};
        `CAP_PCIX_OFF: cap_word = {1'b1, 24'h000000, `CAP_ID_PCIX};
        default:       cap_word = 33'h000000000;
      endcase
    end
  endfunction
  ////////////////////////////////////////////////////////////////
  // inbound address windows
  reg        in_hit;
  reg [1:0]  in_dst;
  reg [31:0] in_xaddr;
  wire [31:0] off0 = in_addr[31:0] & ~win0_limit;
  // window compare, upper half on dac
  wire win0_hit = ((in_addr[31:0] & win0_limit) == win0_base) &&
                  (!in_dac || in_addr[63:32] == win0_upper);
  wire rom_hit  = ((in_addr[31:0] & rom_limit) == rom_base) && !in_dac;
  wire in_cfg   = (in_cmd == `CMD_CFG_RD) || (in_cmd == `CMD_CFG_WR);
  always @*
  begin
    in_hit   = 1'b0;
    in_dst   = `DEST_MEM;
    in_xaddr = in_addr[31:0];
    if (in_cfg)
    begin
      in_hit = 1'b1;
      in_dst = `DEST_CFG;
    end
    else if (win0_hit)
    begin
      in_hit = 1'b1;
      // low 4 KB to message unit
      if (off0[31:`MSG_SPAN_BIT] == 20'h00000)
      begin
        in_dst   = `DEST_MSG;
        in_xaddr = off0;
      end
      else
      begin
        in_dst   = `DEST_MEM;
        in_xaddr = off0 | win0_xlate;
      end
    end
    else if (rom_hit)
    begin
      in_hit   = 1'b1;
      in_dst   = `DEST_ROM;
      in_xaddr = (in_addr[31:0] & ~rom_limit) | rom_xlate;
    end
  end
  ////////////////////////////////////////////////////////////////
  // inbound queues
  wire        in_take = in_valid & in_hit & claimable(in_cmd, in_dac, pcix_mode);
  wire        in_wr   = is_write(in_cmd);
  wire        iwq_full;
  wire        iwq_empty;
  wire        irq_full;
  wire        irq_empty;
  wire [97:0] iwq_out;
  wire [36:0] irq_out;
  wire        iwq_push = in_take & in_wr & ~iwq_full;
  wire        irq_push = in_take & ~in_wr & ~irq_full;
  wire        pick_w   = ~ib_req & ~iwq_empty;
  wire        pick_r   = ~ib_req & iwq_empty & ~irq_empty;
  wire [32:0] cap      = cap_word(irq_out[7:0]);
  wire        cap_loc  = (irq_out[33:32] == `DEST_CFG) & cap[32];
  pend_queue #(.W(98), .D(IN_WR_DEPTH), .AW(2)) in_wr_q (
    .clk   (clk),
    .rst_n (rst_n),
    .push  (iwq_push),
    .din   ({in_dst, in_xaddr, in_data}),
    .pop   (pick_w),
    .dout  (iwq_out),
    .full  (iwq_full),
    .empty (iwq_empty)
  );
  pend_queue #(.W(37), .D(IN_RD_DEPTH), .AW(3)) in_rd_q (
    .clk   (clk),
    .rst_n (rst_n),
    .push  (irq_push),
    .din   ({in_tag, in_dst, in_xaddr}),
    .pop   (pick_r),
    .dout  (irq_out),
    .full  (irq_full),
    .empty (irq_empty)
  );
  ////////////////////////////////////////////////////////////////
  // inbound claim and internal bus initiator
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_claim  <= 1'b0;
      in_retry  <= 1'b0;
      ib_req    <= 1'b0;
      ib_write  <= 1'b0;
      ib_dest   <= `DEST_MEM;
      ib_addr   <= 32'h00000000;
      ib_wdata  <= 64'h0000000000000000;
      cpl_valid <= 1'b0;
      cpl_tag   <= 3'h0;
      cpl_data  <= 64'h0000000000000000;
    end
    else
    begin
      // write posted, read delayed or split
      in_claim  <= iwq_push | irq_push;
      in_retry  <= in_take & (in_wr ? iwq_full : irq_full);
      cpl_valid <= 1'b0;
      // writes drain first so reads see posted data
      if (pick_w)
      begin
        ib_req   <= 1'b1;
        ib_write <= 1'b1;
        ib_dest  <= iwq_out[97:96];
        ib_addr  <= iwq_out[95:64];
        ib_wdata <= iwq_out[63:0];
      end
      else if (pick_r & cap_loc)
      begin
        cpl_valid <= 1'b1;
        cpl_tag   <= irq_out[36:34];
        cpl_data  <= {32'h00000000, cap[31:0]};
      end
      else if (pick_r)
      begin
        // config and message reads by bus
        ib_req   <= 1'b1;
        ib_write <= 1'b0;
        ib_dest  <= irq_out[33:32];
        ib_addr  <= irq_out[31:0];
        cpl_tag  <= irq_out[36:34];
      end
      else if (ib_req & ib_ack)
      begin
        ib_req    <= 1'b0;
        cpl_valid <= ~ib_write;
        cpl_data  <= ib_rdata;
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  // outbound window map
  reg        ob_hit;
  reg [3:0]  ob_c;
  reg        ob_d;
  wire [31:0] ob_low = (ob_addr & `OB_LOW_MASK) | ob_xlate;
  always @*
  begin
    ob_hit = 1'b1;
    ob_d   = 1'b0;
    ob_c   = ob_write ? `CMD_MEM_WR : `CMD_MEM_RD;
    case (ob_addr[31:28])
      `OB_WIN_MEM, `OB_WIN_DAC:
      begin
        ob_d = (ob_addr[31:28] == `OB_WIN_DAC);
        if (ob_write & ob_burst)
          ob_c = `CMD_WR_BLOCK;
        else if (!ob_write & ob_burst)
          ob_c = pcix_mode ? `CMD_RD_BLOCK : `CMD_RD_MULT;
      end
      `OB_WIN_IO:
        ob_c = ob_write ? `CMD_IO_WR : `CMD_IO_RD;
      `OB_WIN_CFG:
        ob_c = ob_write ? `CMD_CFG_WR : `CMD_CFG_RD;
      default:
        ob_hit = 1'b0;
    endcase
  end
  ////////////////////////////////////////////////////////////////
  // outbound queues
  wire         ob_take = ob_valid & ob_hit;
  wire         owq_full;
  wire         owq_empty;
  wire         orq_full;
  wire         orq_empty;
  wire [132:0] owq_out;
  wire [71:0]  orq_out;
  wire         owq_push = ob_take & ob_write & ~owq_full;
  wire         orq_push = ob_take & ~ob_write & ~orq_full;
  wire         ob_pw    = ~pci_req & ~owq_empty;
  wire         ob_pr    = ~pci_req & owq_empty & ~orq_empty;
  wire [63:0]  ob_full_addr = {ob_d ? ob_upper : 32'h00000000, ob_low};
  pend_queue #(.W(133), .D(OB_WR_DEPTH), .AW(2)) ob_wr_q (
    .clk   (clk),
    .rst_n (rst_n),
    .push  (owq_push),
    .din   ({ob_c, ob_d, ob_full_addr, ob_data}),
    .pop   (ob_pw),
    .dout  (owq_out),
    .full  (owq_full),
    .empty (owq_empty)
  );
  pend_queue #(.W(72), .D(OB_RD_DEPTH), .AW(3)) ob_rd_q (
    .clk   (clk),
    .rst_n (rst_n),
    .push  (orq_push),
    .din   ({ob_tag, ob_c, ob_d, ob_full_addr}),
    .pop   (ob_pr),
    .dout  (orq_out),
    .full  (orq_full),
    .empty (orq_empty)
  );
  ////////////////////////////////////////////////////////////////
  // pci initiator
  // no lock pin; cycles issued independently
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ob_accept    <= 1'b0;
      ob_retry     <= 1'b0;
      ob_error     <= 1'b0;
      pci_req      <= 1'b0;
      pci_cmd      <= `CMD_MEM_RD;
      pci_dac      <= 1'b0;
      pci_addr     <= 64'h0000000000000000;
      pci_wdata    <= 64'h0000000000000000;
      ob_rsp_valid <= 1'b0;
      ob_rsp_tag   <= 3'h0;
      ob_rsp_data  <= 64'h0000000000000000;
    end
    else
    begin
      ob_accept    <= owq_push | orq_push;
      ob_retry     <= ob_take & (ob_write ? owq_full : orq_full);
      ob_error     <= ob_valid & ~ob_hit;
      ob_rsp_valid <= 1'b0;
      if (ob_pw)
      begin
        pci_req   <= 1'b1;
        pci_cmd   <= owq_out[132:129];
        pci_dac   <= owq_out[128];
        pci_addr  <= owq_out[127:64];
        pci_wdata <= owq_out[63:0];
      end
      else if (ob_pr)
      begin
        pci_req    <= 1'b1;
        pci_cmd    <= orq_out[68:65];
        pci_dac    <= orq_out[64];
        pci_addr   <= orq_out[63:0];
        ob_rsp_tag <= orq_out[71:69];
      end
      else if (pci_req & pci_done)
      begin
        pci_req      <= 1'b0;
        ob_rsp_valid <= ~is_write(pci_cmd) & (pci_cmd != `CMD_IO_WR);
        ob_rsp_data  <= pci_rdata;
      end
    end
  end
endmodule
`default_nettype wire

/* bridge_defines.vh */
// Contract
// - many transfers pending in both directions
// - inbound: translate address, start internal bus
// - outbound: translate address, start pci cycle
// - first 4 KB of window 0 reaches message unit
// - expansion rom range goes to flash
// - all parts answer as one function
// - pci 64 bit, 66 or 133 MHz
// - internal bus 64 bit up to 333 MHz
// - config shows pm, msi, pci-x capabilities
// - registers reachable from either bus side
// - address windows decide what is claimed
// - eight inbound reads, four inbound writes pending
// - eight outbound reads, four outbound writes pending
// - inbound claimed only inside programmed window, except config commands, claimed at any address
// - outbound command from fixed window map
// - dual address cycles both directions
// - no locked access, no outbound atomicity
// - fixed claimed and generated command sets
// - never 0,1,4,5; 8,9 claimed only
// - conventional mode claims 8,9 after dac
// - posted writes, delayed or split reads
`ifndef BRIDGE_DEFINES_VH
`define BRIDGE_DEFINES_VH
`define CMD_IO_RD     4'h2
`define CMD_IO_WR     4'h3
`define CMD_MEM_RD    4'h6
`define CMD_MEM_WR    4'h7
`define CMD_ALIAS_RD  4'h8
`define CMD_ALIAS_WR  4'h9
`define CMD_CFG_RD    4'ha
`define CMD_CFG_WR    4'hb
`define CMD_RD_MULT   4'hc
`define CMD_DAC       4'hd
`define CMD_RD_BLOCK  4'he
`define CMD_WR_BLOCK  4'hf
`define DEST_MEM      2'h0
`define DEST_MSG      2'h1
`define DEST_ROM      2'h2
`define DEST_CFG      2'h3
`define MSG_SPAN_BIT  12
`define OB_WIN_MEM    4'h8
`define OB_WIN_DAC    4'h9
`define OB_WIN_IO     4'ha
`define OB_WIN_CFG    4'hb
`define OB_LOW_MASK   32'h0fffffff
`define CAP_PTR_OFF   8'h34
`define CAP_PM_OFF    8'h40
`define CAP_MSI_OFF   8'h48
`define CAP_PCIX_OFF  8'h50
`define CAP_ID_PM     8'h01
`define CAP_ID_MSI    8'h05
`define CAP_ID_PCIX   8'h07
`define IN_RD_DEPTH   8
`define IN_WR_DEPTH   4
`define OB_RD_DEPTH   8
`define OB_WR_DEPTH   4
`endif

/* pend_queue.v */
`timescale 1ns/100ps
`default_nettype none
module pend_queue #(
  parameter W  = 8,
  parameter D  = 4,
  parameter AW = 2
) (
  input  wire          clk,
  input  wire          rst_n,
  input  wire          push,
  input  wire [W-1:0]  din,
  input  wire          pop,
  output wire [W-1:0]  dout,
  output wire          full,
  output wire          empty
);
  localparam [AW:0] DEPTH = D[AW:0];
  reg [W-1:0]  mem [0:D-1];
  reg [AW-1:0] wp;
  reg [AW-1:0] rp;
  reg [AW:0]   cnt;
  wire         do_push = push & ~full;
  wire         do_pop  = pop & ~empty;
  assign full  = (cnt == DEPTH);
  assign empty = (cnt == {(AW+1){1'b0}});
  assign dout  = mem[rp];
  // storage needs no reset; cnt guards reads
  always @(posedge clk)
  begin
    if (do_push)
      mem[wp] <= din;
  end
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp  <= {AW{1'b0}};
      rp  <= {AW{1'b0}};
      cnt <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_push)
        wp <= wp + 1'b1;
      if (do_pop)
        rp <= rp + 1'b1;
      if (do_push & ~do_pop)
        cnt <= cnt + 1'b1;
      else if (do_pop & ~do_push)
        cnt <= cnt - 1'b1;
    end
  end
endmodule
`default_nettype wire

/* bridge_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module bridge_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        pcix_mode,
  input wire logic        in_valid,
  input wire logic [3:0]  in_cmd,
  input wire logic        in_dac,
  input wire logic        in_claim,
  input wire logic        in_retry,
  input wire logic        ib_req,
  input wire logic        ib_ack,
  input wire logic [1:0]  ib_dest,
  input wire logic [31:0] ib_addr,
  input wire logic        ob_valid,
  input wire logic [31:0] ob_addr,
  input wire logic        ob_accept,
  input wire logic        ob_error,
  input wire logic        pci_req,
  input wire logic [3:0]  pci_cmd,
  input wire logic [63:0] pci_addr,
  input wire logic        pci_done,
  input wire logic [63:0] pci_rdata,
  input wire logic        ob_rsp_valid,
  input wire logic [63:0] ob_rsp_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////
  property p_no_claim;
    in_valid && in_cmd inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hd} |=> !in_claim && !in_retry;
  endproperty
  a_no_claim: assert property (p_no_claim)
    else $error("refused command was answered");
  property p_alias_conv;
    in_valid && !pcix_mode && !in_dac && in_cmd inside {4'h8, 4'h9} |=> !(in_claim || in_retry);
  endproperty
  a_alias_conv: assert property (p_alias_conv)
    else $error("alias claimed without dual address");
  property p_idle_quiet;
    !in_valid |=> !in_claim && !in_retry;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("answer without request");
  property p_ib_hold;
    ib_req && !ib_ack |=> ib_req && $stable(ib_addr) && $stable(ib_dest);
  endproperty
  a_ib_hold: assert property (p_ib_hold)
    else $error("internal request moved before ack");
  property p_ib_drop;
    ib_req && ib_ack |=> !ib_req;
  endproperty
  a_ib_drop: assert property (p_ib_drop)
    else $error("internal request held after ack");
  property p_msg_span;
    ib_req && ib_dest == 2'h1 |-> ib_addr[31:12] == 20'h0;
  endproperty
  a_msg_span: assert property (p_msg_span)
    else $error("message unit offset beyond 4 KB");
  property p_pci_hold;
    pci_req && !pci_done |=> pci_req && $stable(pci_cmd) && $stable(pci_addr);
  endproperty
  a_pci_hold: assert property (p_pci_hold)
    else $error("pci request moved before done");
  property p_gen_legal;
    pci_req |-> !(pci_cmd inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9}) && (pci_cmd != 4'he || pcix_mode);
  endproperty
  a_gen_legal: assert property (p_gen_legal)
    else $error("illegal command generated");
  property p_ob_unmapped;
    ob_valid && ob_addr[31:30] != 2'b10 |=> ob_error && !ob_accept;
  endproperty
  a_ob_unmapped: assert property (p_ob_unmapped)
    else $error("unmapped outbound address accepted");
  property p_rsp_data;
    pci_req && pci_done && pci_cmd inside {4'h2, 4'h6, 4'ha, 4'hc, 4'he}
      |=> ob_rsp_valid && ob_rsp_data == $past(pci_rdata);
  endproperty
  a_rsp_data: assert property (p_rsp_data)
    else $error("outbound read data not returned");
endmodule
bind pci_internal_bus_translator bridge_chk chk_u (
  .clk(clk), .rst_n(rst_n), .pcix_mode(pcix_mode), .in_valid(in_valid),
  .in_cmd(in_cmd), .in_dac(in_dac), .in_claim(in_claim), .in_retry(in_retry),
  .ib_req(ib_req), .ib_ack(ib_ack), .ib_dest(ib_dest), .ib_addr(ib_addr),
  .ob_valid(ob_valid), .ob_addr(ob_addr), .ob_accept(ob_accept), .ob_error(ob_error),
  .pci_req(pci_req), .pci_cmd(pci_cmd), .pci_addr(pci_addr), .pci_done(pci_done),
  .pci_rdata(pci_rdata), .ob_rsp_valid(ob_rsp_valid), .ob_rsp_data(ob_rsp_data));
`default_nettype wire

/* bus_responder.sv */
`timescale 1ns/100ps
`default_nettype none
module bus_responder (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        slow,
  input  wire logic        req,
  input  wire logic [63:0] addr,
  output var  logic        done,
  output var  logic [63:0] rdata
);
  logic [7:0] wait_cnt;
  wire  logic hit = req && !done && wait_cnt == (slow ? 8'h28 : 8'h01);
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      wait_cnt <= 8'h00;
      done     <= 1'b0;
      rdata    <= 64'h0;
    end
    else
    begin
      done     <= hit;
      wait_cnt <= (req && !done) ? wait_cnt + 8'h01 : 8'h00;
      // stale data inverted every cycle so a sample one cycle late does not match
      rdata    <= hit ? {addr[31:0], ~addr[31:0]} : ~rdata;
    end
endmodule
`default_nettype wire

/* testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHECK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin mismatches++; \
  $display("unexpected %s: expected %h seen %h", what, exp, got); end end
`define WAIT(sig) n = 0; while ((sig) !== 1'b1 && n < 300) begin @(posedge clk); #1; n++; end
module testbench;
  logic        clk, rst_n, pcix_mode, in_valid, in_dac, ob_valid, ob_write, ob_burst, slow;
  logic [3:0]  in_cmd;
  logic [2:0]  in_tag, ob_tag, cpl_tag, ob_rsp_tag;
  logic [31:0] w0b, w0u, w0l, w0x, rb, rl, rx, obx, obu, ob_addr, ib_addr;
  logic [63:0] in_addr, in_data, ob_data, ib_rdata, pci_rdata, pci_addr, pci_wdata;
  logic [63:0] ib_wdata, cpl_data, ob_rsp_data;
  logic        in_claim, in_retry, ib_req, ib_write, ib_ack, cpl_valid, ob_accept, ob_retry;
  logic        ob_error, pci_req, pci_dac, pci_done, ob_rsp_valid;
  logic [1:0]  ib_dest;
  logic [3:0]  pci_cmd;
  int          mismatches, check_count, n;
  pci_internal_bus_translator dut_u (.clk(clk), .rst_n(rst_n), .pcix_mode(pcix_mode),
    .win0_base(w0b), .win0_upper(w0u), .win0_limit(w0l), .win0_xlate(w0x), .rom_base(rb),
    .rom_limit(rl), .rom_xlate(rx), .ob_xlate(obx), .ob_upper(obu), .in_valid(in_valid),
    .in_cmd(in_cmd), .in_dac(in_dac), .in_addr(in_addr), .in_data(in_data), .in_tag(in_tag),
    .in_claim(in_claim), .in_retry(in_retry), .ib_req(ib_req), .ib_write(ib_write),
    .ib_dest(ib_dest), .ib_addr(ib_addr), .ib_wdata(ib_wdata), .ib_ack(ib_ack),
    .ib_rdata(ib_rdata), .cpl_valid(cpl_valid), .cpl_tag(cpl_tag), .cpl_data(cpl_data),
    .ob_valid(ob_valid), .ob_write(ob_write), .ob_burst(ob_burst), .ob_addr(ob_addr),
    .ob_data(ob_data), .ob_tag(ob_tag), .ob_accept(ob_accept), .ob_retry(ob_retry),
    .ob_error(ob_error), .pci_req(pci_req), .pci_cmd(pci_cmd), .pci_dac(pci_dac),
    .pci_addr(pci_addr), .pci_wdata(pci_wdata), .pci_done(pci_done), .pci_rdata(pci_rdata),
    .ob_rsp_valid(ob_rsp_valid), .ob_rsp_tag(ob_rsp_tag), .ob_rsp_data(ob_rsp_data));
  bus_responder ib_u (.clk(clk), .rst_n(rst_n), .slow(slow), .req(ib_req),
    .addr({32'h0, ib_addr}), .done(ib_ack), .rdata(ib_rdata));
  bus_responder pci_u (.clk(clk), .rst_n(rst_n), .slow(slow), .req(pci_req),
    .addr(pci_addr), .done(pci_done), .rdata(pci_rdata));
  ////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic drain;
    int idle;
    idle = 0;
    repeat (3000)
      if (idle < 6)
      begin
        @(posedge clk);
        #1;
        idle = (ib_req || pci_req) ? 0 : idle + 1;
      end
    @(posedge clk);
  endtask
  // returns {taken, retry, 0}; inbound has no error bit
  task automatic in_req(input logic [3:0] c, input logic d, input logic [63:0] a,
                        output logic [2:0] f);
    @(posedge clk);
    in_valid <= 1'b1;
    in_cmd   <= c;
    in_dac   <= d;
    in_addr  <= a;
    in_data  <= ~a;
    in_tag   <= a[5:3];
    @(posedge clk);
    in_valid <= 1'b0;
    #1 f = {in_claim, in_retry, 1'b0};
  endtask
  task automatic ob_req(input logic w, input logic b, input logic [31:0] a,
                        output logic [2:0] f);
    @(posedge clk);
    ob_valid <= 1'b1;
    ob_write <= w;
    ob_burst <= b;
    ob_addr  <= a;
    ob_data  <= ~{32'h0, a};
    ob_tag   <= a[5:3];
    @(posedge clk);
    ob_valid <= 1'b0;
    #1 f = {ob_accept, ob_retry, ob_error};
  endtask
  task automatic in_one(input logic [3:0] c, input logic d, input logic [63:0] a,
                        input logic [1:0] dest, input logic [31:0] ea);
    logic [2:0] f;
    in_req(c, d, a, f);
    `WAIT(ib_req)
    `CHECK("ib_dest", dest, ib_dest)
    `CHECK("ib_addr", ea, ib_addr)
    `CHECK("ib_write", c[0], ib_write)
    if (c[0])
      `CHECK("ib_wdata", ~a, ib_wdata)
    else
    begin
      `WAIT(cpl_valid)
      `CHECK("cpl_data", {ea, ~ea}, cpl_data)
      `CHECK("cpl_tag", a[5:3], cpl_tag)
    end
    drain;
  endtask
  task automatic ob_one(input logic w, input logic b, input logic [31:0] a,
                        input logic [3:0] cmd, input logic dac);
    logic [2:0]  f;
    logic [63:0] ea;
    ea = {dac ? obu : 32'h0, a & 32'h0fff_ffff | obx};
    ob_req(w, b, a, f);
    `CHECK("ob_accept", 3'b100, f)
    `WAIT(pci_req)
    `CHECK("pci_cmd", cmd, pci_cmd)
    `CHECK("pci_dac", dac, pci_dac)
    `CHECK("pci_addr", ea, pci_addr)
    if (w)
      `CHECK("pci_wdata", ~{32'h0, a}, pci_wdata)
    else
    begin
      `WAIT(ob_rsp_valid)
      `CHECK("ob_rsp_data", {ea[31:0], ~ea[31:0]}, ob_rsp_data)
      `CHECK("ob_rsp_tag", a[5:3], ob_rsp_tag)
    end
    drain;
  endtask
  // capability chain read, answered without the internal bus
  task automatic cap_rd(input logic [7:0] o, input logic [63:0] e);
    logic [2:0] f;
    in_req(4'ha, 1'b0, {56'h0, o}, f);
    `WAIT(cpl_valid)
    `CHECK("cap_word", e, cpl_data)
    `CHECK("cap ib_req", 1'b0, ib_req)
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic s_cmds;
    logic [2:0] f;
    for (int m = 0; m < 2; m++)
    begin
      pcix_mode <= m[0];
      for (int d = 0; d < 2; d++)
        for (int c = 0; c < 16; c++)
        begin
          in_req(c[3:0], d[0], {d[0] ? w0u : 32'h0, w0b | 32'h2000}, f);
          `CHECK("claim", c inside {6, 7, 10, 11, 12, 14, 15} || (c inside {8, 9} && (m || d)), |f)
        end
      drain;
    end
  endtask
  task automatic s_inbound;
    logic [2:0] f;
    pcix_mode <= 1'b0;
    cap_rd(8'h34, 64'h40);
    cap_rd(8'h40, 64'h4801);
    cap_rd(8'h48, 64'h5005);
    cap_rd(8'h50, 64'h07);
    in_req(4'h6, 1'b0, 64'h5000_0000, f);
    `CHECK("miss", 3'b000, f)
    in_req(4'h6, 1'b1, {w0u + 32'h1, w0b}, f);
    `CHECK("dac miss", 3'b000, f)
    in_one(4'h6, 1'b1, {w0u, w0b | 32'h2008}, 2'h0, 32'h2008 | w0x);
    in_one(4'h7, 1'b0, {32'h0, w0b | 32'h10}, 2'h1, 32'h10);
    in_one(4'h7, 1'b0, {32'h0, w0b | 32'h1000}, 2'h0, 32'h1000 | w0x);
    in_one(4'he, 1'b0, {32'h0, rb | 32'h100}, 2'h2, 32'h100 | rx);
    pcix_mode <= 1'b1;
    in_one(4'h8, 1'b0, {32'h0, w0b | 32'h3000}, 2'h0, 32'h3000 | w0x);
  endtask
  task automatic s_outbound;
    logic [2:0] f;
    pcix_mode <= 1'b0;
    ob_req(1'b0, 1'b0, 32'h4000_0000, f);
    `CHECK("ob unmapped", 3'b001, f)
    ob_one(1'b0, 1'b0, 32'h8123_4568, 4'h6, 1'b0);
    ob_one(1'b0, 1'b1, 32'h8000_0080, 4'hc, 1'b0);
    ob_one(1'b1, 1'b1, 32'h8000_00c0, 4'hf, 1'b0);
    ob_one(1'b1, 1'b0, 32'h9000_0100, 4'h7, 1'b1);
    ob_one(1'b0, 1'b0, 32'ha000_0010, 4'h2, 1'b0);
    ob_one(1'b1, 1'b0, 32'ha000_0018, 4'h3, 1'b0);
    ob_one(1'b0, 1'b0, 32'hb000_0020, 4'ha, 1'b0);
    ob_one(1'b1, 1'b0, 32'hb000_0028, 4'hb, 1'b0);
    pcix_mode <= 1'b1;
    ob_one(1'b0, 1'b1, 32'h8000_0040, 4'he, 1'b0);
  endtask
  // slow far side: depth plus at most one in flight
  task automatic s_queues;
    logic [2:0] f;
    int         nc, nr, cap;
    slow <= 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      nc = 0;
      nr = 0;
      cap = k[0] ? 4 : 8;
      for (int i = 0; i < 12; i++)
      begin
        if (k < 2)
          in_req(k[0] ? 4'h7 : 4'h6, 1'b0, {32'h0, w0b | 32'h2000}, f);
        else
          ob_req(k[0], 1'b0, 32'h8000_0000, f);
        nc += f[2];
        nr += f[1];
      end
      `CHECK("queue depth", 1'b1, nc == cap || nc == cap + 1)
      `CHECK("retries", 1'b1, nc + nr == 12)
      drain;
    end
    slow <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    repeat (60000) @(posedge clk);
    mismatches++;
    tally_and_finish;
  end
  initial
  begin
    {rst_n, pcix_mode, in_valid, in_dac, ob_valid, ob_write, ob_burst, slow} = 8'h00;
    {in_cmd, in_tag, ob_tag, ob_addr, in_addr, in_data, ob_data} = '0;
    {w0b, w0u, w0l, w0x} = {32'h4000_0000, 32'h0000_0007, 32'hfff0_0000, 32'h0010_0000};
    {rb, rl, rx, obx, obu} = {32'h6000_0000, 32'hffff_0000, 32'h0080_0000, 32'h2000_0000, 32'h3};
    mismatches = 0;
    check_count = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    s_cmds;
    s_inbound;
    s_outbound;
    s_queues;
    tally_and_finish;
  end
endmodule
`default_nettype wire
